/* File: logic/pia_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Two 8-bit ports, each bit set as input or output by software.
// - Four control inputs, two per port, for interrupts or handshakes.
// - Active strobe edge sets flag 7; control bit 1 picks rising edge.
// - Bit 0 set lets flag 7 pull the port interrupt low.
// - Aux line input when bit 5 clear; its edge, per bit 4, sets flag 6.
// - In input mode, bit 3 set lets flag 6 pull the interrupt low.
// - Port A handshake: aux high on strobe edge, low on data read.
// - Port A pulse mode: aux low one cycle after each data read.
// - Port A manual mode: aux low for 110, high for 111.
// - Port B handshake: aux low on data write, high on strobe edge.
// - Port B pulse mode: aux low one cycle after each data write.
// - Port B manual mode: aux low for 110, high for 111.
module pia_top
	import pia_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [DATA_W-1:0] port_a_in,
	output logic [DATA_W-1:0] port_a_out,
	output logic [DATA_W-1:0] port_a_oe,
	input wire logic [DATA_W-1:0] port_b_in,
	output logic [DATA_W-1:0] port_b_out,
	output logic [DATA_W-1:0] port_b_oe,
	input wire logic port_a_strobe_in,
	input wire logic port_b_strobe_in,
	input wire logic port_a_aux_line_in,
	output logic port_a_aux_line_out,
	output logic port_a_aux_line_oe,
	input wire logic port_b_aux_line_in,
	output logic port_b_aux_line_out,
	output logic port_b_aux_line_oe,
	output logic port_a_irq_n,
	output logic port_b_irq_n,
	output logic irq
);
	pia_top_s q, d;

	// Synchronised copies of every pin input
	logic [SYNC_W-1:0] pins_async;
	logic [SYNC_W-1:0] pins_sync;
	logic [DATA_W-1:0] a_pins;
	logic [DATA_W-1:0] b_pins;

	// Per-port control channel wiring
	logic [NUM_PORTS-1:0] ctl_wr;
	logic [NUM_PORTS-1:0] access;
	logic [NUM_PORTS-1:0] flag_clr;
	pia_ctl_out_s ctl_out [NUM_PORTS];

	// Bus decode
	logic addr_take;
	logic rd_take;
	logic wr_take;
	logic mapped;
	logic [7:0] rd_off;
	logic [7:0] wr_off;
	logic wr_commit;
	logic rd_a_data;
	logic rd_b_data;
	logic wr_b_data;
	logic [31:0] rd_word;
	logic [DATA_W-1:0] a_rd_val;
	logic [DATA_W-1:0] b_rd_val;
	logic [NUM_EV-1:0] events;
	logic [NUM_EV-1:0] w1c;

	// Gather pin inputs into the synchroniser lanes
	assign pins_async = {port_b_aux_line_in, port_a_aux_line_in,
		port_b_strobe_in, port_a_strobe_in, port_b_in, port_a_in};

	pia_sync u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(pins_async),
		.sync_out(pins_sync)
	);

	assign a_pins = pins_sync[SY_A_PINS +: DATA_W];
	assign b_pins = pins_sync[SY_B_PINS +: DATA_W];

	// One control channel per port: flags, aux line and irq
	generate
		for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
			pia_port_ctl u_ctl (
				.hclk(hclk),
				.hresetn(hresetn),
				.strobe_in(pins_sync[SY_A_STB + p]),
				.aux_in(pins_sync[SY_A_AUX + p]),
				.ctl_wr(ctl_wr[p]),
				.ctl_wdata(hwdata[CTL_WR_W-1:0]),
				.access(access[p]),
				.flag_clr(flag_clr[p]),
				.ctl_out(ctl_out[p])
			);
		end
	endgenerate

	// Address phase qualification; only word transfers are expected
	always_comb begin
		addr_take = hsel && htrans[1] && hready;
		mapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
		rd_take = addr_take && !hwrite;
		wr_take = addr_take && hwrite;
		rd_off = haddr[7:0];
		wr_off = q.wr_addr;
		wr_commit = q.wr_pend;
	end

	// Side-effect strobes from data accesses, plus the control register write strobes
	always_comb begin
		rd_a_data = rd_take && mapped && (rd_off == OFF_A_DATA);
		rd_b_data = rd_take && mapped && (rd_off == OFF_B_DATA);
		wr_b_data = wr_commit && (wr_off == OFF_B_DATA);
		access[0] = rd_a_data;
		access[1] = wr_b_data;
		flag_clr[0] = rd_a_data;
		flag_clr[1] = rd_b_data;
		ctl_wr[0] = wr_commit && (wr_off == OFF_A_CTL);
		ctl_wr[1] = wr_commit && (wr_off == OFF_B_CTL);
	end

	// Port read value: output bits echo the latch, input bits the pins
	always_comb begin
		a_rd_val = (q.a_dir & q.a_data) | (~q.a_dir & a_pins);
		b_rd_val = (q.b_dir & q.b_data) | (~q.b_dir & b_pins);
	end

	// Read multiplexer; unmapped addresses read as zero
	always_comb begin
		rd_word = 32'h00000000;
		if (mapped) begin
			unique case (rd_off)
				OFF_A_DATA: rd_word[DATA_W-1:0] = a_rd_val;
				OFF_A_DIR: rd_word[DATA_W-1:0] = q.a_dir;
				OFF_A_CTL: rd_word[DATA_W-1:0] = ctl_out[0].ctl_rd;
				OFF_B_DATA: rd_word[DATA_W-1:0] = b_rd_val;
				OFF_B_DIR: rd_word[DATA_W-1:0] = q.b_dir;
				OFF_B_CTL: rd_word[DATA_W-1:0] = ctl_out[1].ctl_rd;
				OFF_IRQ_STATUS: rd_word[NUM_EV-1:0] = q.status;
				OFF_IRQ_MASK: rd_word[NUM_EV-1:0] = q.mask;
				default: rd_word = 32'h00000000;
			endcase
		end
	end

	// Flag-setting events feed the sticky status bits
	always_comb begin
		events = '0;
		events[ST_A1] = ctl_out[0].ev1;
		events[ST_A2] = ctl_out[0].ev2;
		events[ST_B1] = ctl_out[1].ev1;
		events[ST_B2] = ctl_out[1].ev2;
		w1c = '0;
		if (wr_commit && (wr_off == OFF_IRQ_STATUS)) begin
			w1c = hwdata[NUM_EV-1:0];
		end
	end

	// Next state of the bus slave and the register file
	always_comb begin
		d = q;
		d.resp = 1'b0;
		// Mapped writes take one wait state so data lands before the next access
		if (wr_commit) begin
			d.wr_pend = 1'b0;
			d.ready = 1'b1;
			unique case (wr_off)
				OFF_A_DATA: d.a_data = hwdata[DATA_W-1:0];
				OFF_A_DIR: d.a_dir = hwdata[DATA_W-1:0];
				OFF_B_DATA: d.b_data = hwdata[DATA_W-1:0];
				OFF_B_DIR: d.b_dir = hwdata[DATA_W-1:0];
				OFF_IRQ_MASK: d.mask = hwdata[NUM_EV-1:0];
				default: d.mask = q.mask;
			endcase
		end
		if (wr_take) begin
			d.wr_pend = mapped;
			d.wr_addr = rd_off;
			d.ready = !mapped;
		end
		// Read data is registered at the address phase edge
		if (rd_take) begin
			d.rdata = rd_word;
		end
		// Sticky status: a new event wins over a clear
		d.status = (q.status & ~w1c) | events;
		d.irq = |(d.status & d.mask);
	end

	// State registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '{a_data: DATA_RST, a_dir: DIR_RST, b_data: DATA_RST,
				b_dir: DIR_RST, mask: MASK_RST, ready: 1'b1,
				default: '0};
		end else begin
			q <= d;
		end
	end

	// Outputs
	assign hreadyout = q.ready;
	assign hresp = q.resp;
	assign hrdata = q.rdata;
	assign port_a_out = q.a_data;
	assign port_a_oe = q.a_dir;
	assign port_b_out = q.b_data;
	assign port_b_oe = q.b_dir;
	assign port_a_aux_line_out = ctl_out[0].aux_out;
	assign port_a_aux_line_oe = ctl_out[0].aux_oe;
	assign port_b_aux_line_out = ctl_out[1].aux_out;
	assign port_b_aux_line_oe = ctl_out[1].aux_oe;
	assign port_a_irq_n = ctl_out[0].irq_n;
	assign port_b_irq_n = ctl_out[1].irq_n;
	assign irq = q.irq;
endmodule : pia_top

/* File: logic/pia_pkg.sv */
package pia_pkg;

	// Widths
	localparam int DATA_W = 8;
	localparam int NUM_PORTS = 2;
	localparam int NUM_EV = 4;
	localparam int CTL_WR_W = 6;

	// Register byte offsets
	localparam logic [7:0] OFF_A_DATA = 8'h00;
	localparam logic [7:0] OFF_A_DIR = 8'h04;
	localparam logic [7:0] OFF_A_CTL = 8'h08;
	localparam logic [7:0] OFF_B_DATA = 8'h0c;
	localparam logic [7:0] OFF_B_DIR = 8'h10;
	localparam logic [7:0] OFF_B_CTL = 8'h14;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;

	// Control register field positions
	localparam int CTL_IRQ1_EN = 0;
	localparam int CTL_EDGE1 = 1;
	localparam int CTL_IRQ2_EN = 3;
	localparam int CTL_EDGE2 = 4;
	localparam int CTL_AUX_OUT = 5;
	localparam int CTL_FLAG2 = 6;
	localparam int CTL_FLAG1 = 7;

	// Output modes of the aux line, control bits 5..3
	localparam logic [2:0] MODE_HANDSHAKE = 3'h4;
	localparam logic [2:0] MODE_PULSE = 3'h5;
	localparam logic [2:0] MODE_LOW = 3'h6;
	localparam logic [2:0] MODE_HIGH = 3'h7;

	// Interrupt status bit positions
	localparam int ST_A1 = 0;
	localparam int ST_A2 = 1;
	localparam int ST_B1 = 2;
	localparam int ST_B2 = 3;

	// Reset values
	localparam logic [CTL_WR_W-1:0] CTL_RST = 6'h00;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [DATA_W-1:0] DIR_RST = 8'h00;
	localparam logic [NUM_EV-1:0] MASK_RST = 4'h0;
	localparam logic AUX_RST = 1'b1;

	// Synchroniser lane layout
	localparam int SYNC_W = 20;
	localparam int SY_A_PINS = 0;
	localparam int SY_B_PINS = 8;
	localparam int SY_A_STB = 16;
	localparam int SY_A_AUX = 18;

	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
	} pia_sync_s;

	typedef struct packed {
		logic [CTL_WR_W-1:0] ctl;
		logic flag1;
		logic flag2;
		logic stb_prev;
		logic aux_prev;
		logic armed;
		logic aux_out;
		logic irq_n;
	} pia_ctl_s;

	typedef struct packed {
		logic [DATA_W-1:0] ctl_rd;
		logic ev1;
		logic ev2;
		logic aux_out;
		logic aux_oe;
		logic irq_n;
	} pia_ctl_out_s;

	typedef struct packed {
		logic [DATA_W-1:0] a_data;
		logic [DATA_W-1:0] a_dir;
		logic [DATA_W-1:0] b_data;
		logic [DATA_W-1:0] b_dir;
		logic [NUM_EV-1:0] status;
		logic [NUM_EV-1:0] mask;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic ready;
		logic resp;
		logic irq;
	} pia_top_s;

endpackage : pia_pkg

/* File: logic/pia_sync.sv */
`timescale 1ns/1ps
module pia_sync
	import pia_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [SYNC_W-1:0] async_in,
	output logic [SYNC_W-1:0] sync_out
);
	pia_sync_s q, d;

	// Two-stage chain; only the second stage is seen outside
	always_comb begin
		d = q;
		d.s1 = async_in;
		d.s2 = q.s1;
	end

	// State registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_out = q.s2;
endmodule : pia_sync

/* File: logic/pia_port_ctl.sv */
`timescale 1ns/1ps
module pia_port_ctl
	import pia_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic strobe_in,
	input wire logic aux_in,
	input wire logic ctl_wr,
	input wire logic [CTL_WR_W-1:0] ctl_wdata,
	input wire logic access,
	input wire logic flag_clr,
	output pia_ctl_out_s ctl_out
);
	pia_ctl_s q, d;
	logic ev1;
	logic ev2;
	logic [2:0] mode;

	// Edge detection on synchronised lines, polarity per control bit
	always_comb begin
		mode = q.ctl[CTL_AUX_OUT:CTL_IRQ2_EN];
		ev1 = q.armed && (q.ctl[CTL_EDGE1] ? (strobe_in && !q.stb_prev)
			: (!strobe_in && q.stb_prev));
		ev2 = q.armed && !q.ctl[CTL_AUX_OUT] && (q.ctl[CTL_EDGE2]
			? (aux_in && !q.aux_prev) : (!aux_in && q.aux_prev));
	end

	// Next state
	always_comb begin
		d = q;
		d.stb_prev = strobe_in;
		d.aux_prev = aux_in;
		d.armed = 1'b1;
		// Only bits 0..5 are writable
		if (ctl_wr) begin
			d.ctl = ctl_wdata;
		end
		// A data read clears flags; a new edge wins
		if (flag_clr) begin
			d.flag1 = 1'b0;
			d.flag2 = 1'b0;
		end
		if (ev1) begin
			d.flag1 = 1'b1;
		end
		if (ev2) begin
			d.flag2 = 1'b1;
		end
		// Aux line output behaviour
		unique case (mode)
			MODE_HANDSHAKE: begin
				if (ev1) begin
					d.aux_out = 1'b1;
				end else if (access) begin
					d.aux_out = 1'b0;
				end
			end
			MODE_PULSE: d.aux_out = !access;
			MODE_LOW: d.aux_out = 1'b0;
			MODE_HIGH: d.aux_out = 1'b1;
			default: d.aux_out = AUX_RST;
		endcase
		// Active-low interrupt from enabled flags
		d.irq_n = !((d.flag1 && d.ctl[CTL_IRQ1_EN])
			|| (d.flag2 && d.ctl[CTL_IRQ2_EN]
			&& !d.ctl[CTL_AUX_OUT]));
	end

	// State registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '{ctl: CTL_RST, aux_out: AUX_RST, irq_n: 1'b1,
				default: 1'b0};
		end else begin
			q <= d;
		end
	end

	// Outputs straight from state, except ev1 and ev2, which also use the line inputs
	always_comb begin
		ctl_out.ctl_rd = {q.flag1, q.flag2, q.ctl};
		ctl_out.ev1 = ev1;
		ctl_out.ev2 = ev2;
		ctl_out.aux_out = q.aux_out;
		ctl_out.aux_oe = q.ctl[CTL_AUX_OUT];
		ctl_out.irq_n = q.irq_n;
	end
endmodule : pia_port_ctl

/* File: sim/pia_monitor.sv */
`timescale 1ns/1ps
module pia_monitor
	import pia_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic port_a_aux_line_out,
	input wire logic port_a_aux_line_oe,
	input wire logic port_b_aux_line_out,
	input wire logic port_a_irq_n,
	input wire logic port_b_irq_n
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic pa_q, pb_q, sa, sb;
	logic [5:0] ca_q, cb_q, ca1_q, cb1_q, ca2_q, cb2_q;
	logic tk;
	assign tk = hsel && htrans[1] && hready && hwrite;
	// Shadow of control bits 5..0 as committed in the write data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{pa_q, pb_q} <= 2'h0;
			{ca_q, cb_q, ca1_q, cb1_q, ca2_q, cb2_q} <= '0;
		end else begin
			pa_q <= tk && haddr == {24'h0, OFF_A_CTL};
			pb_q <= tk && haddr == {24'h0, OFF_B_CTL};
			if (pa_q) ca_q <= hwdata[5:0];
			if (pb_q) cb_q <= hwdata[5:0];
			{ca2_q, ca1_q, cb2_q, cb1_q} <= {ca1_q, ca_q, cb1_q, cb_q};
		end
	end
	// Mode settled for two cycles, so registered outputs have caught up
	assign sa = ca_q == ca1_q && ca_q == ca2_q;
	assign sb = cb_q == cb1_q && cb_q == cb2_q;
	property p_ctl_wait;
		tk && haddr == {24'h0, OFF_A_CTL} |=> !hreadyout ##1 hreadyout;
	endproperty
	a_ctl_wait: assert property (p_ctl_wait)
		else $error("control write without one wait cycle");
	property p_a_man;
		sa && ca_q[5:4] == 2'h3 |-> port_a_aux_line_out == ca_q[3];
	endproperty
	a_a_man: assert property (p_a_man)
		else $error("port a manual level wrong");
	property p_b_man;
		sb && cb_q[5:4] == 2'h3 |-> port_b_aux_line_out == cb_q[3];
	endproperty
	a_b_man: assert property (p_b_man)
		else $error("port b manual level wrong");
	property p_a_pulse;
		sa && ca_q[5:3] == MODE_PULSE && $fell(port_a_aux_line_out)
			|=> port_a_aux_line_out;
	endproperty
	a_a_pulse: assert property (p_a_pulse)
		else $error("port a pulse not one cycle");
	property p_b_pulse;
		sb && cb_q[5:3] == MODE_PULSE && $fell(port_b_aux_line_out)
			|=> port_b_aux_line_out;
	endproperty
	a_b_pulse: assert property (p_b_pulse)
		else $error("port b pulse not one cycle");
	property p_a_oe;
		sa |-> port_a_aux_line_oe == ca_q[5];
	endproperty
	a_a_oe: assert property (p_a_oe)
		else $error("port a aux direction wrong");
	property p_a_quiet;
		sa && !ca_q[0] && !(ca_q[3] && !ca_q[5]) |-> port_a_irq_n;
	endproperty
	a_a_quiet: assert property (p_a_quiet)
		else $error("port a interrupt low while disabled");
	property p_b_quiet;
		sb && !cb_q[0] && !(cb_q[3] && !cb_q[5]) |-> port_b_irq_n;
	endproperty
	a_b_quiet: assert property (p_b_quiet)
		else $error("port b interrupt low while disabled");
	c_pulse: cover property (sa && ca_q[5:3] == MODE_PULSE
		&& !port_a_aux_line_out);
	c_irq_a: cover property (!port_a_irq_n);
	c_irq_b: cover property (!port_b_irq_n && cb_q[3]);
endmodule : pia_monitor

bind pia_top pia_monitor i_mon (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hreadyout, .port_a_aux_line_out,
	.port_a_aux_line_oe, .port_b_aux_line_out, .port_a_irq_n,
	.port_b_irq_n);

/* File: sim/pia_periph.sv */
`timescale 1ns/1ps
module pia_periph
	import pia_pkg::*;
(
	input wire logic hclk,
	input wire logic [DATA_W-1:0] pa_out,
	input wire logic [DATA_W-1:0] pa_oe,
	input wire logic xa_out,
	input wire logic xa_oe,
	input wire logic xb_out,
	input wire logic xb_oe,
	output logic [DATA_W-1:0] pa_in,
	output logic stb_a,
	output logic stb_b,
	output logic xa_in,
	output logic xb_in
);
	// Port A aux line has a pull-up, so released it reads high
	logic [3:0] lv_q = 4'h2;
	logic [DATA_W-1:0] pd_q = 8'h3c;
	// Wire levels: whichever side has the line enabled drives it
	assign pa_in = (pa_oe & pa_out) | (~pa_oe & pd_q);
	assign xa_in = xa_oe ? xa_out : lv_q[1];
	assign xb_in = xb_oe ? xb_out : lv_q[3];
	assign stb_a = lv_q[0];
	assign stb_b = lv_q[2];
	// Move one line just after an edge, after an optional stall
	task automatic drive(input int w, input logic v, input int stall);
		repeat (stall) @(posedge hclk);
		@(posedge hclk);
		lv_q[w] <= v;
	endtask : drive
endmodule : pia_periph

/* File: sim/tb.sv */
`timescale 1ns/1ps
`define CK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
fails++; $display("Error %0t: got %h want %h", $time, a, b); end end
module tb
	import pia_pkg::*;
;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, irq, port_a_irq_n, port_b_irq_n;
	logic [7:0] port_a_in, port_a_out, port_a_oe;
	logic [7:0] port_b_in = 8'h0c, port_b_out, port_b_oe;
	logic port_a_strobe_in, port_b_strobe_in;
	logic port_a_aux_line_in, port_a_aux_line_out, port_a_aux_line_oe;
	logic port_b_aux_line_in, port_b_aux_line_out, port_b_aux_line_oe;
	int fails = 0, samples_checked = 0, cyc = 0;
	int lo_a = 0, lo_b = 0;
	always #4 hclk = ~hclk;
	// Low cycles of the aux outputs, counted mid-cycle
	always @(negedge hclk) begin
		lo_a += int'(!port_a_aux_line_out);
		lo_b += int'(!port_b_aux_line_out);
	end
	pia_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.port_a_in, .port_a_out, .port_a_oe, .port_b_in, .port_b_out,
		.port_b_oe, .port_a_strobe_in, .port_b_strobe_in,
		.port_a_aux_line_in, .port_a_aux_line_out, .port_a_aux_line_oe,
		.port_b_aux_line_in, .port_b_aux_line_out, .port_b_aux_line_oe,
		.port_a_irq_n, .port_b_irq_n, .irq);
	pia_periph i_per (.hclk, .pa_out(port_a_out), .pa_oe(port_a_oe),
		.xa_out(port_a_aux_line_out), .xa_oe(port_a_aux_line_oe),
		.xb_out(port_b_aux_line_out), .xb_oe(port_b_aux_line_oe),
		.pa_in(port_a_in), .stb_a(port_a_strobe_in),
		.stb_b(port_b_strobe_in), .xa_in(port_a_aux_line_in),
		.xb_in(port_b_aux_line_in));
	// One single transfer; hready is sampled at the rising edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask : wr
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		`CK(r, e)
	endtask : chk
	task automatic t_ctl;
		chk(OFF_A_CTL, 32'h0);
		wr(OFF_A_CTL, 32'hff);
		chk(OFF_A_CTL, 32'h3f);
		chk(8'h20, 32'h0);
		wr(OFF_A_DIR, 32'h0f);
		wr(OFF_A_DATA, 32'ha5);
		repeat (2) @(negedge hclk);
		`CK({port_a_oe, port_a_out}, 16'h0fa5)
		chk(OFF_A_DATA, 32'h35);
		wr(OFF_B_DIR, 32'hf0);
		wr(OFF_B_DATA, 32'h5a);
		repeat (2) @(negedge hclk);
		`CK({port_b_oe, port_b_out}, 16'hf05a)
		chk(OFF_B_DATA, 32'h5c);
		wr(OFF_B_DIR, 32'h00);
	endtask : t_ctl
	// Falling strobe sets the flag; status, mask and clear of irq
	task automatic t_flag;
		wr(OFF_A_CTL, 32'h01);
		i_per.drive(0, 1'b1, 0);
		repeat (4) @(posedge hclk);
		chk(OFF_A_CTL, 32'h01);
		i_per.drive(0, 1'b0, 3);
		repeat (4) @(posedge hclk);
		`CK({port_a_irq_n, irq}, 2'h0)
		chk(OFF_A_CTL, 32'h81);
		wr(OFF_IRQ_MASK, 32'h1);
		chk(OFF_A_DATA, 32'h35);
		repeat (2) @(negedge hclk);
		`CK({port_a_irq_n, irq}, 2'h3)
		wr(OFF_IRQ_STATUS, 32'h1);
		repeat (2) @(negedge hclk);
		`CK(irq, 1'b0)
	endtask : t_flag
	task automatic t_aux;
		wr(OFF_B_CTL, 32'h18);
		i_per.drive(3, 1'b1, 1);
		repeat (4) @(posedge hclk);
		`CK(port_b_irq_n, 1'b0)
		chk(OFF_B_CTL, 32'h58);
		chk(OFF_B_DATA, 32'h0c);
		chk(OFF_B_CTL, 32'h18);
	endtask : t_aux
	task automatic t_hs;
		wr(OFF_A_CTL, 32'h22);
		chk(OFF_A_DATA, 32'h35);
		`CK(port_a_aux_line_out, 1'b0)
		i_per.drive(0, 1'b1, 0);
		repeat (4) @(posedge hclk);
		`CK(port_a_aux_line_out, 1'b1)
		wr(OFF_B_CTL, 32'h22);
		wr(OFF_B_DATA, 32'h77);
		`CK(port_b_aux_line_out, 1'b0)
		i_per.drive(2, 1'b1, 2);
		repeat (4) @(posedge hclk);
		`CK(port_b_aux_line_out, 1'b1)
	endtask : t_hs
	// Each access gives exactly one low cycle, then the line is high
	task automatic t_pulse;
		int n;
		wr(OFF_A_CTL, 32'h28);
		wr(OFF_B_CTL, 32'h28);
		n = lo_a;
		chk(OFF_A_DATA, 32'h35);
		repeat (2) @(posedge hclk);
		`CK(lo_a - n, 1)
		`CK(port_a_aux_line_out, 1'b1)
		n = lo_b;
		wr(OFF_B_DATA, 32'h01);
		repeat (2) @(posedge hclk);
		`CK(lo_b - n, 1)
		`CK(port_b_aux_line_out, 1'b1)
	endtask : t_pulse
	task automatic t_man;
		for (int m = 6; m < 8; m++) begin
			wr(OFF_A_CTL, 32'(m << 3));
			wr(OFF_B_CTL, 32'(m << 3));
			repeat (2) @(negedge hclk);
			`CK(port_a_aux_line_out, m[0])
			`CK(port_b_aux_line_out, m[0])
		end
	endtask : t_man
	// Reset in mid-run: every output except port_a_out checked back at its idle level
	task automatic t_rst;
		@(posedge hclk);
		hresetn <= 1'b0;
		@(negedge hclk);
		`CK({hreadyout, hresp, irq, port_a_irq_n, port_b_irq_n}, 5'h13)
		`CK({port_a_aux_line_out, port_a_aux_line_oe}, 2'h2)
		`CK({port_b_aux_line_out, port_b_aux_line_oe}, 2'h2)
		`CK({port_a_oe, port_b_oe, port_b_out, hrdata}, 56'h0)
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		chk(OFF_A_CTL, 32'h0);
	endtask : t_rst
	task automatic wrap_up;
		$display("checks %0d errors %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up
	// Hang guard
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			wrap_up();
		end
	end
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_ctl();
		t_flag();
		t_aux();
		t_hs();
		t_pulse();
		t_man();
		t_rst();
		wrap_up();
	end
endmodule : tb
